/* rtl/flash_burst_read_config_defines.svh */
// constants for the burst read configuration block
// Summary of operation
// - read_mode_select one gives asynchronous page reads (default); zero gives synchronous burst.
// - read_mode_select is bit 15, reset value one.
// - latency_code bits 13:11, codes 2 to 7, reset 7, others reserved.
// - latency_code clocks pass from address strobe until first data drives the bus.
// - no wait states inside one word line at a correct latency code; here the one-word toggle handshake inserts wait states between words.
// - bit 10 wait polarity: zero active low, one active high (default).
// - bit 9 data hold: zero one clock per word, one two clocks (default).
// - bit 8 wait delay: zero deasserts with data, one a data cycle early.
// - bit 3 burst_wrap: zero wraps within burst length, one no wrap (default).
// - bits 2:0 burst length 4, 8, 16 words or continuous (default).
// - some packages present the configuration word on address lines 16:1.
// - only linear order; burst_order set means linear, cleared is reserved.
// - synchronous wait stays asserted until bus data is valid.
// - word written by configure command, read back at identifier offset 0x05.
`ifndef FLASH_BURST_READ_CONFIG_DEFINES_SVH
`define FLASH_BURST_READ_CONFIG_DEFINES_SVH
`define RC_RESET        16'hBFCF
`define RC_USED_MASK    16'hBFCF
`define RC_MODE_BIT     15
`define RC_LAT_HI       13
`define RC_LAT_LO       11
`define RC_WAIT_POL_BIT 10
`define RC_HOLD_BIT     9
`define RC_WAIT_DLY_BIT 8
`define RC_ORDER_BIT    7
`define RC_EDGE_BIT     6
`define RC_WRAP_BIT     3
`define RC_LEN_HI       2
`define RC_LEN_LO       0
`define RC_ID_OFFSET    16'h0005
`define RC_LAT_MIN      3'h2
`define BL_4            3'h1
`define BL_8            3'h2
`define BL_16           3'h3
`define BL_CONT         3'h7
`endif

/* rtl/flash_burst_read_config_pkg.sv */
// types for the burst read configuration block
package flash_burst_read_config_pkg;
  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_LATENCY,
    LINK_DATA
  } link_state_t;
endpackage

/* rtl/burst_word_fifo.sv */
// small valid/ready word fifo, used across the clock boundary feed
`timescale 1ns/10ps
module burst_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
    next_rd_ptr = pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

/* rtl/flash_burst_read_config.sv */
// read configuration word and synchronous burst output timing
`timescale 1ns/10ps
`include "flash_burst_read_config_defines.svh"
module flash_burst_read_config
  import flash_burst_read_config_pkg::*;
(
  // system side
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // command side: configure strobe with word, identifier read
  input  wire logic        cfg_write,
  input  wire logic        cfg_addr_hi,
  input  wire logic [16:0] cfg_addr,
  input  wire logic        id_read,
  input  wire logic [15:0] id_offset,
  output logic      [15:0] id_data,
  output logic             id_data_valid,
  // array word feed toward the link
  input  wire logic        word_valid,
  output logic             word_ready,
  input  wire logic [15:0] word_data,
  // configuration view for the rest of the device
  output logic             sync_mode,
  output logic      [3:0]  burst_words,
  output logic             burst_wrap_en,
  // link side, on the host clock
  input  wire logic        link_clk,
  input  wire logic        chip_enable_n,
  input  wire logic        address_valid_n,
  output logic      [15:0] dq_out,
  output logic             dq_oe,
  output logic             wait_out,
  output logic             wait_oe
);
  logic [15:0] read_configuration;
  logic [15:0] next_read_configuration;
  logic [15:0] next_id_data;
  logic        next_id_data_valid;

  // pick the word off the low or high address lines by package variant
  function automatic logic [15:0] decode_word(input logic hi, input logic [16:0] a);
    decode_word = hi ? a[16:1] : a[15:0];
  endfunction

  always_comb begin
    next_read_configuration = read_configuration;
    next_id_data            = id_data;
    next_id_data_valid      = 1'b0;
    if (cfg_write) begin
      // reserved bits kept zero, burst order forced linear
      next_read_configuration = (decode_word(cfg_addr_hi, cfg_addr) & `RC_USED_MASK)
                                | (16'h0001 << `RC_ORDER_BIT);
    end
    if (id_read) begin
      next_id_data_valid = 1'b1;
      next_id_data       = (id_offset == `RC_ID_OFFSET) ? read_configuration : 16'h0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      read_configuration <= `RC_RESET;
      id_data            <= 16'h0000;
      id_data_valid      <= 1'b0;
    end else begin
      read_configuration <= next_read_configuration;
      id_data            <= next_id_data;
      id_data_valid      <= next_id_data_valid;
    end
  end

  logic [2:0] len_code;
  assign len_code      = read_configuration[`RC_LEN_HI:`RC_LEN_LO];
  assign sync_mode     = !read_configuration[`RC_MODE_BIT];
  assign burst_wrap_en = !read_configuration[`RC_WRAP_BIT];
  always_comb begin
    unique case (len_code)
      `BL_4:   burst_words = 4'h3;
      `BL_8:   burst_words = 4'h7;
      `BL_16:  burst_words = 4'hF;
      default: burst_words = 4'h0;
    endcase
  end

  // words cross through the fifo; it is written on sys_clk, so a toggle handshake
  // moves one word at a time to the link domain and stalls the fifo meanwhile
  logic        fifo_valid;
  logic        fifo_ready;
  logic [15:0] fifo_data;
  burst_word_fifo #(.WIDTH(16), .DEPTH(4)) u_fifo (
    .clk       (sys_clk),
    .rst       (sys_rst),
    .in_valid  (word_valid),
    .in_ready  (word_ready),
    .in_data   (word_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  logic        req_tgl;
  logic        next_req_tgl;
  logic [15:0] xfer_word;
  logic [15:0] next_xfer_word;
  logic        ack_s1;
  logic        ack_s2;
  logic        ack_tgl;
  logic        busy;
  assign busy       = (req_tgl != ack_s2);
  assign fifo_ready = !busy;
  always_comb begin
    next_req_tgl   = req_tgl;
    next_xfer_word = xfer_word;
    if (fifo_valid && !busy) begin
      next_req_tgl   = !req_tgl;
      next_xfer_word = fifo_data;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      req_tgl   <= 1'b0;
      xfer_word <= 16'h0000;
      ack_s1    <= 1'b0;
      ack_s2    <= 1'b0;
    end else begin
      req_tgl   <= next_req_tgl;
      xfer_word <= next_xfer_word;
      ack_s1    <= ack_tgl;
      ack_s2    <= ack_s1;
    end
  end

  // the configuration word crosses by a toggle handshake: the shadow copy reloads only
  // after the link side has taken the previous one, so it never moves while sampled
  logic [15:0] cfg_shadow;
  logic [15:0] next_cfg_shadow;
  logic        cfg_req_tgl;
  logic        next_cfg_req_tgl;
  logic        cfg_ack_tgl;
  logic        next_cfg_ack_tgl;
  logic        cfg_ack_s1;
  logic        cfg_ack_s2;
  always_comb begin
    next_cfg_shadow  = cfg_shadow;
    next_cfg_req_tgl = cfg_req_tgl;
    if ((cfg_req_tgl == cfg_ack_s2) && (cfg_shadow != read_configuration)) begin
      next_cfg_shadow  = read_configuration;
      next_cfg_req_tgl = !cfg_req_tgl;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_shadow  <= `RC_RESET;
      cfg_req_tgl <= 1'b0;
      cfg_ack_s1  <= 1'b0;
      cfg_ack_s2  <= 1'b0;
    end else begin
      cfg_shadow  <= next_cfg_shadow;
      cfg_req_tgl <= next_cfg_req_tgl;
      cfg_ack_s1  <= cfg_ack_tgl;
      cfg_ack_s2  <= cfg_ack_s1;
    end
  end

  // two-flop synchronisers on the host clock; they only move while that clock runs
  logic        cfg_req_s1;
  logic        cfg_req_s2;
  logic        req_s1;
  logic        req_s2;
  logic        rst_s1;
  logic        rst_s2;
  always_ff @(posedge link_clk) begin
    cfg_req_s1 <= cfg_req_tgl;
    cfg_req_s2 <= cfg_req_s1;
    req_s1     <= req_tgl;
    req_s2     <= req_s1;
    rst_s1     <= sys_rst;
    rst_s2     <= rst_s1;
  end

  // taken on the raw host clock, since the edge select below depends on it
  logic [15:0] link_cfg;
  logic [15:0] next_link_cfg;
  always_comb begin
    next_link_cfg    = link_cfg;
    next_cfg_ack_tgl = cfg_ack_tgl;
    if (cfg_req_s2 != cfg_ack_tgl) begin
      next_link_cfg    = cfg_shadow;
      next_cfg_ack_tgl = cfg_req_s2;
    end
  end
  always_ff @(posedge link_clk) begin
    if (rst_s2) begin
      link_cfg    <= `RC_RESET;
      cfg_ack_tgl <= 1'b0;
    end else begin
      link_cfg    <= next_link_cfg;
      cfg_ack_tgl <= next_cfg_ack_tgl;
    end
  end

  // link logic runs on the host clock edge; falling edge chosen by an inverted clock
  logic edge_rise;
  logic lclk;
  assign edge_rise = link_cfg[`RC_EDGE_BIT];
  assign lclk      = edge_rise ? link_clk : !link_clk;

  link_state_t state;
  link_state_t next_state;
  logic [2:0]  lat_cnt;
  logic [2:0]  next_lat_cnt;
  logic        hold_cnt;
  logic        next_hold_cnt;
  logic        have_word;
  logic        next_have_word;
  logic        next_ack_tgl;
  logic [15:0] next_dq_out;
  logic        adv_prev;
  logic        word_pending;
  logic        take;
  logic        sync_l;
  logic        wait_active;
  logic        early;
  logic        data_valid;
  logic [2:0]  link_lat;

  assign sync_l       = !link_cfg[`RC_MODE_BIT];
  assign word_pending = (req_s2 != ack_tgl);
  assign early        = link_cfg[`RC_WAIT_DLY_BIT];
  assign link_lat     = link_cfg[`RC_LAT_HI:`RC_LAT_LO];

  // reserved codes below two run at the shortest legal latency
  function automatic logic [2:0] first_latency(input logic [2:0] code);
    first_latency = (code < `RC_LAT_MIN) ? `RC_LAT_MIN : code;
  endfunction

  always_comb begin
    next_state     = state;
    next_lat_cnt   = lat_cnt;
    next_hold_cnt  = hold_cnt;
    next_have_word = have_word;
    next_ack_tgl   = ack_tgl;
    next_dq_out    = dq_out;
    take           = 1'b0;
    if (chip_enable_n || !sync_l) begin
      next_state     = LINK_IDLE;
      next_have_word = 1'b0;
    end else begin
      unique case (state)
        LINK_IDLE: begin
          // address taken at strobe rise or first edge while strobe low
          if (!address_valid_n || (adv_prev == 1'b0 && address_valid_n)) begin
            next_state   = LINK_LATENCY;
            next_lat_cnt = first_latency(link_lat);
          end
        end
        LINK_LATENCY: begin
          if (lat_cnt > 3'h1) begin
            next_lat_cnt = lat_cnt - 3'h1;
          end else if (word_pending) begin
            take = 1'b1;
          end
          // stall here only when no word arrived in time
        end
        LINK_DATA: begin
          if (hold_cnt) begin
            next_hold_cnt = 1'b0;
          end else if (word_pending) begin
            take = 1'b1;
          end else begin
            next_have_word = 1'b0;
          end
        end
        default: next_state = LINK_IDLE;
      endcase
      // a fresh strobe restarts the access from any state; the host clock may stop
      // between frames, so the end of a frame may not be seen with enable high
      if (adv_prev && !address_valid_n && (state != LINK_IDLE)) begin
        take           = 1'b0;
        next_state     = LINK_LATENCY;
        next_lat_cnt   = first_latency(link_lat);
        next_hold_cnt  = 1'b0;
        next_have_word = 1'b0;
      end
      if (take) begin
        next_state     = LINK_DATA;
        next_dq_out    = xfer_word;
        next_ack_tgl   = !ack_tgl;
        next_have_word = 1'b1;
        next_hold_cnt  = link_cfg[`RC_HOLD_BIT];
      end
    end
  end

  always_ff @(posedge lclk) begin
    if (rst_s2) begin
      state     <= LINK_IDLE;
      lat_cnt   <= 3'h0;
      hold_cnt  <= 1'b0;
      have_word <= 1'b0;
      ack_tgl   <= 1'b0;
      dq_out    <= 16'h0000;
      adv_prev  <= 1'b1;
    end else begin
      state     <= next_state;
      lat_cnt   <= next_lat_cnt;
      hold_cnt  <= next_hold_cnt;
      have_word <= next_have_word;
      ack_tgl   <= next_ack_tgl;
      dq_out    <= next_dq_out;
      adv_prev  <= address_valid_n;
    end
  end

  // wait asserted until data valid; early mode drops it one data cycle sooner, before the first word only
  assign data_valid  = (state == LINK_DATA) && have_word;
  assign wait_active = sync_l && !(data_valid || (early && state == LINK_LATENCY
                       && lat_cnt == 3'h1 && word_pending));
  assign wait_out    = link_cfg[`RC_WAIT_POL_BIT] ? wait_active : !wait_active;
  assign wait_oe     = !chip_enable_n;
  assign dq_oe       = !chip_enable_n && sync_l && data_valid;
endmodule

/* testbench/flash_burst_read_config_chk.sv */
// assertions on the burst read configuration ports
`timescale 1ns/10ps
module flash_burst_read_config_chk (
  // system side
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // command side
  input wire logic        cfg_write,
  input wire logic        cfg_addr_hi,
  input wire logic [16:0] cfg_addr,
  input wire logic        id_read,
  input wire logic [15:0] id_offset,
  input wire logic [15:0] id_data,
  input wire logic        id_data_valid,
  // configuration view
  input wire logic        sync_mode,
  input wire logic [3:0]  burst_words,
  input wire logic        burst_wrap_en,
  // link side
  input wire logic        link_clk,
  input wire logic        chip_enable_n,
  input wire logic        wait_oe,
  input wire logic        dq_oe,
  input wire logic        wait_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [15:0] w;
  assign w = cfg_addr_hi ? cfg_addr[16:1] : cfg_addr[15:0];
  property p_ans; id_read |=> id_data_valid; endproperty
  a_ans: assert property (p_ans) else $error("no answer to identifier read");
  property p_off; id_read && id_offset != 16'h0005 |=> id_data == 16'h0000; endproperty
  a_off: assert property (p_off) else $error("other offset not zero");
  property p_mode; cfg_write |=> sync_mode != $past(w[15]); endproperty
  a_mode: assert property (p_mode) else $error("read mode not taken");
  property p_hi; cfg_write && cfg_addr_hi |=> burst_wrap_en != $past(cfg_addr[4]); endproperty
  a_hi: assert property (p_hi) else $error("upper address word not decoded");
  property p_wrap; cfg_write && !cfg_addr_hi |=> burst_wrap_en != $past(cfg_addr[3]); endproperty
  a_wrap: assert property (p_wrap) else $error("wrap bit not taken");
  property p_len; cfg_write && w[2:0] == 3'h1 |=> burst_words == 4'h3; endproperty
  a_len: assert property (p_len) else $error("four word length wrong");
  property p_back;
    id_read && id_offset == 16'h0005 |=> id_data[15] != $past(sync_mode) && id_data[7];
  endproperty
  a_back: assert property (p_back) else $error("readback disagrees with mode");
  property p_res; id_data_valid |-> !id_data[14] && id_data[5:4] == 2'h0; endproperty
  a_res: assert property (p_res) else $error("reserved bit read as one");
  property p_oe;
    @(posedge link_clk) disable iff (sys_rst) !chip_enable_n |-> wait_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("wait not driven while enabled");
  property p_wait;
    @(posedge link_clk) disable iff (sys_rst)
      $rose(dq_oe) |-> $changed(wait_out) || ($past(wait_out) != $past(wait_out, 2));
  endproperty
  a_wait: assert property (p_wait) else $error("wait did not release around first data");
  c_data: cover property (@(posedge link_clk) $rose(dq_oe));
  c_hi: cover property (cfg_write && cfg_addr_hi);
  c_len: cover property (cfg_write && w[2:0] == 3'h1);
  c_back: cover property (id_read && id_offset == 16'h0005);
endmodule
bind flash_burst_read_config flash_burst_read_config_chk chk (
  .sys_clk, .sys_rst, .cfg_write, .cfg_addr_hi, .cfg_addr, .id_read, .id_offset,
  .id_data, .id_data_valid, .sync_mode, .burst_words, .burst_wrap_en,
  .link_clk, .chip_enable_n, .wait_oe, .dq_oe, .wait_out
);

/* testbench/host_link_model.sv */
// host side of the burst link: clock, enable and address strobe
`timescale 1ns/10ps
module host_link_model (
  // strobes toward the device
  output logic             link_clk,
  output logic             chip_enable_n,
  output logic             address_valid_n,
  // answer from the device
  input  wire logic [15:0] dq_out,
  input  wire logic        dq_oe,
  input  wire logic        wait_out
);
  initial begin
    link_clk = 1'b0;
    chip_enable_n = 1'b1;
    address_valid_n = 1'b1;
  end
  // clock stands still between frames, so config crosses only inside one
  task automatic frame(input int edges, output int first, output logic [15:0] word, output logic wt);
    first = -1;
    word = 16'h0000;
    wt = 1'b1;
    #7 chip_enable_n = 1'b0;
    address_valid_n = 1'b0;
    for (int e = 0; e < edges; e++) begin
      #16 link_clk = 1'b1;
      #1 address_valid_n = 1'b1;
      if (dq_oe === 1'b1 && first < 0) begin
        first = e;
        word = dq_out;
        wt = wait_out;
      end
      #15 link_clk = 1'b0;
    end
    #16 chip_enable_n = 1'b1;
  endtask
endmodule

/* testbench/flash_burst_read_config_bench.sv */
// self-checking bench for the burst read configuration block
`timescale 1ns/10ps
module flash_burst_read_config_bench;
  logic        sys_clk, sys_rst, cfg_write, cfg_addr_hi, id_read, word_valid, wt;
  logic [16:0] cfg_addr;
  logic [15:0] id_offset, word_data, id_data, dq_out, got, word, cv;
  logic        id_data_valid, word_ready, sync_mode, burst_wrap_en;
  logic [3:0]  burst_words;
  logic        link_clk, chip_enable_n, address_valid_n, dq_oe, wait_out, wait_oe;
  logic [31:0] seed, r;
  logic [2:0]  bl;
  int          num_errors, samples_checked, first;
  assign cv = {sync_mode, burst_wrap_en, 10'h000, burst_words};
  flash_burst_read_config dut (.sys_clk, .sys_rst, .cfg_write, .cfg_addr_hi, .cfg_addr, .id_read,
    .id_offset, .id_data, .id_data_valid, .word_valid, .word_ready, .word_data, .sync_mode,
    .burst_words, .burst_wrap_en, .link_clk, .chip_enable_n, .address_valid_n, .dq_out, .dq_oe,
    .wait_out, .wait_oe);
  host_link_model host (.link_clk, .chip_enable_n, .address_valid_n, .dq_out, .dq_oe, .wait_out);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("errors %0d, comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // reserved bits drop out, burst order always reads linear
  function automatic logic [15:0] stored(input logic [15:0] v);
    return (v & 16'hBFCF) | 16'h0080;
  endfunction
  function automatic logic [15:0] view(input logic [15:0] v);
    logic [3:0] n;
    n = v[2:0] == 3'h1 ? 4'h3 : v[2:0] == 3'h2 ? 4'h7 : v[2:0] == 3'h3 ? 4'hF : 4'h0;
    return {~v[15], ~v[3], 10'h000, n};
  endfunction
  task automatic cfg(input logic hi, input logic [15:0] v);
    @(posedge sys_clk);
    cfg_write <= 1'b1;
    cfg_addr_hi <= hi;
    cfg_addr <= hi ? {v, 1'b0} : {1'b0, v};
    @(posedge sys_clk);
    cfg_write <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] off);
    @(posedge sys_clk);
    id_read <= 1'b1;
    id_offset <= off;
    @(posedge sys_clk);
    id_read <= 1'b0;
    #1 check({15'h0000, id_data_valid}, 16'h0001);
    got = id_data;
  endtask
  task automatic push(input logic [15:0] v);
    int n;
    n = 0;
    @(posedge sys_clk);
    word_valid <= 1'b1;
    word_data <= v;
    do begin
      @(posedge sys_clk);
      n++;
    end while (word_ready !== 1'b1 && n < 20);
    word_valid <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      final_report();
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #2000000 num_errors++;
    final_report();
  end
  initial begin
    seed = 32'h6e7d726a;
    num_errors = 0;
    samples_checked = 0;
    {sys_rst, cfg_write, cfg_addr_hi, id_read, word_valid} = 5'h10;
    {cfg_addr, id_offset, word_data} = '0;
    // link reset needs link edges as well
    host.frame(6, first, got, wt);
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(16'h0005);
    check(got, 16'hBFCF);
    check(cv, 16'h0000);
    rd(16'h0004);
    check(got, 16'h0000);
    repeat (8) begin
      r = $random(seed);
      cfg(r[16], r[15:0]);
      rd(16'h0005);
      check(got, stored(r[15:0]));
      check(cv, view(r[15:0]));
    end
    for (int c = 3; c <= 7; c++) begin
      bl = c < 6 ? 3'(c - 2) : 3'h7;
      word = {2'b00, c[2:0], 5'b10011, 2'b00, 1'b1, bl};
      cfg(1'b0, word);
      // enough link edges for the configuration handshake to settle
      host.frame(12, first, got, wt);
      r = $random(seed);
      push(r[15:0]);
      host.frame(c + 1, first, got, wt);
      check(first[15:0], c[15:0]);
      check(got, r[15:0]);
      check({15'h0000, wt}, 16'h0000);
    end
    // link stalled, so the fifo can only fill
    repeat (4) push(16'h5A5A);
    @(posedge sys_clk);
    word_valid <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check({15'h0000, word_ready}, 16'h0000);
    word_valid <= 1'b0;
    final_report();
  end
endmodule
